// ===== inc/trig_seq_cfg.svh
// constants for the trigger sequencer: sizes, widths and reset values
// assumes inclusion by bare name from the package and the design files
`ifndef TRIG_SEQ_CFG_SVH
`define TRIG_SEQ_CFG_SVH

`define SEQ_STATES      16
`define STATE_IDX_W     4
`define NUM_COUNTERS    4
`define COUNTER_W       16
`define NUM_FLAGS       4
`define MAX_CMP         16
`define PROBE_W_DEF     32
`define CMP_DEF         4
`define COUNTER_RESET   16'h0000
`define COUNTER_STEP    16'h0001
`define FLAGS_RESET     4'h0
`define FIRST_STATE     4'h0

`endif

// ===== inc/trig_seq_pkg.sv
// types shared by the trigger sequencer and its probe comparators
// assumes trig_seq_cfg.svh is on the include path
`include "trig_seq_cfg.svh"

package trig_seq_pkg;

    // branch form of one program state
    typedef enum logic [1:0] {
        BR_ONE,
        BR_TWO,
        BR_THREE
    } branch_t;

    // probe comparator operations; edge ops look at probe bit 0
    typedef enum logic [3:0] {
        OP_EQ,
        OP_NE,
        OP_GT,
        OP_LT,
        OP_GE,
        OP_LE,
        OP_RISE,
        OP_FALL,
        OP_ANY_EDGE,
        OP_NO_EDGE
    } cmp_op_t;

    // counter comparator supports equality and inequality
    typedef enum logic {
        CNT_EQ,
        CNT_NE
    } cnt_op_t;

    // sequencer run mode
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_RUN,
        SEQ_DONE
    } seq_mode_t;

    typedef struct packed {
        cnt_op_t                op;
        logic [`COUNTER_W-1:0]  value;
    } counter_cmp_t;

    // one branch condition: probe comparator group and optional counter
    typedef struct packed {
        logic [`MAX_CMP-1:0]      probe_mask;
        logic                     probe_and;
        logic                     cnt_use;
        logic [1:0]               cnt_sel;
        logic                     cnt_and;
    } condition_t;

    // one action block: flag and counter actions, then goto or trigger
    typedef struct packed {
        logic                     fire;
        logic [`STATE_IDX_W-1:0]  goto_state;
        logic [`NUM_FLAGS-1:0]    flag_set;
        logic [`NUM_FLAGS-1:0]    flag_clear;
        logic [`NUM_COUNTERS-1:0] cnt_inc;
        logic [`NUM_COUNTERS-1:0] cnt_clr;
    } action_block_t;

    typedef struct packed {
        branch_t                  kind;
        condition_t               cond_first;
        condition_t               cond_second;
        action_block_t            act_first;
        action_block_t            act_second;
        action_block_t            act_default;
    } state_body_t;

endpackage

// ===== rtl/probe_comparator.sv
// one trigger comparator on the probe port
// assumes the probe comes from user logic on sys_clk, so no synchroniser
`timescale 1ns/1ps
`include "trig_seq_cfg.svh"

module probe_comparator
    import trig_seq_pkg::*;
#(
    parameter int PROBE_W = `PROBE_W_DEF
) (
    input  wire logic               sys_clk,  // sampling clock
    input  wire logic               rst,      // sync reset, high
    input  wire logic [PROBE_W-1:0] probe,    // probed user signals
    input  wire cmp_op_t            op,       // comparison operation
    input  wire logic [PROBE_W-1:0] value,    // compare constant
    input  wire logic [PROBE_W-1:0] care,     // 0 bits are don't care, EQ/NE only
    output logic                    match     // comparison result
);

    logic prev_bit;
    logic next_prev_bit;
    logic [PROBE_W-1:0] masked_probe;
    logic [PROBE_W-1:0] masked_value;

    // previous sample of bit 0 for edge matching
    always_comb begin
        next_prev_bit = probe[0];
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            prev_bit <= 1'b0;
        end else begin
            prev_bit <= next_prev_bit;
        end
    end

    assign masked_probe = probe & care;
    assign masked_value = value & care;

    always_comb begin
        case (op)
            OP_EQ:       match = (masked_probe == masked_value);
            OP_NE:       match = (masked_probe != masked_value);
            OP_GT:       match = (probe > value);
            OP_LT:       match = (probe < value);
            OP_GE:       match = (probe >= value);
            OP_LE:       match = (probe <= value);
            OP_RISE:     match = ~prev_bit & probe[0];
            OP_FALL:     match = prev_bit & ~probe[0];
            OP_ANY_EDGE: match = prev_bit ^ probe[0];
            OP_NO_EDGE:  match = ~(prev_bit ^ probe[0]);
            default:     match = 1'b0;
        endcase
    end

endmodule

// ===== rtl/trigger_sequencer_fsm.sv
// programmable trigger sequencer of the embedded logic analyser core
// assumes the host loads program and compare settings while not running
// and that probes come from user logic clocked by sys_clk
//
// Operation
// - program holds up to sixteen states
// - branch form chosen per state
// - one-way goes straight to successor
// - two-way picks first or alternative
// - three-way, first condition beats second
// - goto makes named state active next
// - trigger action asserts capture trigger
// - four sixteen-bit event counters
// - counters clear, count up, feed conditions
// - four progress flags visible to host
// - flags set, cleared, otherwise held
// - one equality or inequality comparator per counter
// - one to sixteen probe comparators
// - magnitude, equality and edge probe compares
`timescale 1ns/1ps
`include "trig_seq_cfg.svh"

module trigger_sequencer_fsm
    import trig_seq_pkg::*;
#(
    parameter int PROBE_W = `PROBE_W_DEF,
    parameter int NUM_CMP = `CMP_DEF
) (
    input  wire logic                      sys_clk,            // sampling clock
    input  wire logic                      rst,                // sync reset, high
    input  wire logic [PROBE_W-1:0]        probe,              // probed user signals
    input  wire logic                      prog_we,            // program word write
    input  wire logic [`STATE_IDX_W-1:0]   prog_addr,          // state being written
    input  wire state_body_t               prog_word,          // state body
    input  wire cmp_op_t                   cmp_op [NUM_CMP],   // probe comparator ops
    input  wire logic [PROBE_W-1:0]        cmp_value [NUM_CMP], // probe constants
    input  wire logic [PROBE_W-1:0]        cmp_care [NUM_CMP], // probe care masks
    input  wire counter_cmp_t              cnt_cmp [`NUM_COUNTERS], // counter compares
    input  wire logic                      arm,                // start request pulse
    input  wire logic                      disarm,             // stop request pulse
    output logic                           running,            // sequencer active
    output logic                           trigger_out,        // capture trigger pulse
    output logic                           triggered,          // trigger has fired
    output logic [`STATE_IDX_W-1:0]        active_state,       // current program state
    output logic                           progress_marker_zero,  // flag 0
    output logic                           progress_marker_one,   // flag 1
    output logic                           progress_marker_two,   // flag 2
    output logic                           progress_marker_three, // flag 3
    output logic [`COUNTER_W-1:0]          event_count_zero,   // counter 0
    output logic [`COUNTER_W-1:0]          event_count_one,    // counter 1
    output logic [`COUNTER_W-1:0]          event_count_two,    // counter 2
    output logic [`COUNTER_W-1:0]          event_count_three   // counter 3
);

    // program memory and sequencer state
    state_body_t                prog [`SEQ_STATES];
    state_body_t                next_prog [`SEQ_STATES];
    seq_mode_t                  mode;
    seq_mode_t                  next_mode;
    logic [`STATE_IDX_W-1:0]    cur_state;
    logic [`STATE_IDX_W-1:0]    next_cur_state;
    logic [`COUNTER_W-1:0]      cnt [`NUM_COUNTERS];
    logic [`COUNTER_W-1:0]      next_cnt [`NUM_COUNTERS];
    logic [`NUM_FLAGS-1:0]      flags;
    logic [`NUM_FLAGS-1:0]      next_flags;
    logic                       trig_pulse;
    logic                       next_trig_pulse;
    logic                       trig_seen;
    logic                       next_trig_seen;

    // evaluation wires
    logic [`MAX_CMP-1:0]        probe_match;
    logic [`NUM_COUNTERS-1:0]   cnt_match;
    state_body_t                body;
    logic                       first_true;
    logic                       second_true;
    action_block_t              act;

    // combine the probe group and the counter term of one condition;
    // an empty condition counts as true so a blank program still steps
    function automatic logic cond_eval(
        input condition_t               c,
        input logic [`MAX_CMP-1:0]      pm,
        input logic [`NUM_COUNTERS-1:0] cm
    );
        logic probe_term;
        logic cnt_term;
        logic has_probe;
        begin
            has_probe  = |c.probe_mask;
            probe_term = c.probe_and ? &(pm | ~c.probe_mask)
                                     : |(pm & c.probe_mask);
            cnt_term   = cm[c.cnt_sel];
            if (has_probe && c.cnt_use) begin
                cond_eval = c.cnt_and ? (probe_term & cnt_term)
                                      : (probe_term | cnt_term);
            end else if (has_probe) begin
                cond_eval = probe_term;
            end else if (c.cnt_use) begin
                cond_eval = cnt_term;
            end else begin
                cond_eval = 1'b1;
            end
        end
    endfunction

    genvar g;
    generate
        for (g = 0; g < `MAX_CMP; g = g + 1) begin : gen_cmp
            if (g < NUM_CMP) begin : gen_used
                probe_comparator #(
                    .PROBE_W (PROBE_W)
                ) u_cmp (
                    .sys_clk (sys_clk),
                    .rst     (rst),
                    .probe   (probe),
                    .op      (cmp_op[g]),
                    .value   (cmp_value[g]),
                    .care    (cmp_care[g]),
                    .match   (probe_match[g])
                );
            end else begin : gen_absent
                // a mask bit for an absent comparator never matches
                assign probe_match[g] = 1'b0;
            end
        end
    endgenerate

    always_comb begin
        for (int i = 0; i < `NUM_COUNTERS; i++) begin
            if (cnt_cmp[i].op == CNT_EQ) begin
                cnt_match[i] = (cnt[i] == cnt_cmp[i].value);
            end else begin
                cnt_match[i] = (cnt[i] != cnt_cmp[i].value);
            end
        end
    end

    always_comb begin
        for (int i = 0; i < `SEQ_STATES; i++) begin
            next_prog[i] = prog[i];
        end
        if (prog_we && (mode != SEQ_RUN)) begin
            next_prog[prog_addr] = prog_word;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i < `SEQ_STATES; i++) begin
                prog[i] <= '0;
            end
        end else begin
            for (int i = 0; i < `SEQ_STATES; i++) begin
                prog[i] <= next_prog[i];
            end
        end
    end

    // conditions use counter values from before this cycle's actions
    assign body        = prog[cur_state];
    assign first_true  = cond_eval(body.cond_first, probe_match, cnt_match);
    assign second_true = cond_eval(body.cond_second, probe_match, cnt_match);

    always_comb begin
        case (body.kind)
            BR_ONE: begin
                act = body.act_first;
            end
            BR_TWO: begin
                act = first_true ? body.act_first : body.act_default;
            end
            BR_THREE: begin
                if (first_true) begin
                    act = body.act_first;
                end else if (second_true) begin
                    act = body.act_second;
                end else begin
                    act = body.act_default;
                end
            end
            default: begin
                act = body.act_default;
            end
        endcase
    end

    // sequencer step: arm, run one state per clock, stop on trigger
    always_comb begin
        next_mode       = mode;
        next_cur_state  = cur_state;
        next_flags      = flags;
        next_trig_pulse = 1'b0;
        next_trig_seen  = trig_seen;
        for (int i = 0; i < `NUM_COUNTERS; i++) begin
            next_cnt[i] = cnt[i];
        end
        case (mode)
            SEQ_IDLE,
            SEQ_DONE: begin
                if (arm) begin
                    next_mode      = SEQ_RUN;
                    next_cur_state = `FIRST_STATE;
                    next_flags     = `FLAGS_RESET;
                    next_trig_seen = 1'b0;
                    for (int i = 0; i < `NUM_COUNTERS; i++) begin
                        next_cnt[i] = `COUNTER_RESET;
                    end
                end
            end
            SEQ_RUN: begin
                if (disarm) begin
                    next_mode = SEQ_IDLE;
                end else begin
                    for (int i = 0; i < `NUM_COUNTERS; i++) begin
                        if (act.cnt_clr[i]) begin
                            next_cnt[i] = `COUNTER_RESET;
                        end else if (act.cnt_inc[i]) begin
                            next_cnt[i] = cnt[i] + `COUNTER_STEP;
                        end
                    end
                    next_flags = (flags & ~act.flag_clear) | act.flag_set;
                    if (act.fire) begin
                        next_trig_pulse = 1'b1;
                        next_trig_seen  = 1'b1;
                        next_mode       = SEQ_DONE;
                    end else begin
                        next_cur_state = act.goto_state;
                    end
                end
            end
            default: begin
                next_mode = SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mode        <= SEQ_IDLE;
            cur_state   <= `FIRST_STATE;
            flags       <= `FLAGS_RESET;
            trig_pulse  <= 1'b0;
            trig_seen   <= 1'b0;
            for (int i = 0; i < `NUM_COUNTERS; i++) begin
                cnt[i] <= `COUNTER_RESET;
            end
        end else begin
            mode        <= next_mode;
            cur_state   <= next_cur_state;
            flags       <= next_flags;
            trig_pulse  <= next_trig_pulse;
            trig_seen   <= next_trig_seen;
            for (int i = 0; i < `NUM_COUNTERS; i++) begin
                cnt[i] <= next_cnt[i];
            end
        end
    end

    // status toward the host from flip-flops; running is decoded from the mode register
    assign running      = (mode == SEQ_RUN);
    assign trigger_out  = trig_pulse;
    assign triggered    = trig_seen;
    assign active_state = cur_state;

    assign progress_marker_zero  = flags[0];
    assign progress_marker_one   = flags[1];
    assign progress_marker_two   = flags[2];
    assign progress_marker_three = flags[3];

    assign event_count_zero  = cnt[0];
    assign event_count_one   = cnt[1];
    assign event_count_two   = cnt[2];
    assign event_count_three = cnt[3];

endmodule

// ===== tb/probe_source.sv
// stand-in for the probed user logic, registered on the sampling clock
// assumes the bench changes next_probe away from the rising edge
`timescale 1ns/1ps

module probe_source #(
    parameter int PROBE_W = 32
) (
    input  wire logic               sys_clk,    // sampling clock
    input  wire logic               rst,        // sync reset, high
    input  wire logic [PROBE_W-1:0] next_probe, // value user logic presents next
    output logic      [PROBE_W-1:0] probe       // registered probe value
);
    // registered like real user logic, so the probe never moves mid-cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            probe <= '0;
        end else begin
            probe <= next_probe;
        end
    end
endmodule

// ===== tb/trigger_sequencer_fsm_monitor.sv
// checker for run, trigger and counter timing of the trigger sequencer
// assumes it is bound to the sequencer top and sees only its ports
`timescale 1ns/1ps
`include "trig_seq_cfg.svh"

module trigger_sequencer_fsm_monitor (
    input wire logic                    sys_clk,              // sampling clock
    input wire logic                    rst,                  // sync reset, high
    input wire logic                    arm,                  // start request
    input wire logic                    disarm,               // stop request
    input wire logic                    running,              // sequencer active
    input wire logic                    trigger_out,          // trigger pulse
    input wire logic                    triggered,            // trigger fired
    input wire logic [`STATE_IDX_W-1:0] active_state,         // current state
    input wire logic                    progress_marker_zero, // flag 0
    input wire logic [`COUNTER_W-1:0]   event_count_zero      // counter 0
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    arm_start_a: assert property (arm && !running |=> running &&
        active_state == 4'h0 && event_count_zero == 16'h0000 && !triggered
        && !progress_marker_zero) else $error("arm did not start cleared");
    trig_pulse_a: assert property (trigger_out |=> !trigger_out)
        else $error("trigger pulse longer than one cycle");
    trig_end_a: assert property (trigger_out |-> triggered && !running
        && $past(running)) else $error("trigger without ending the run");
    trig_seen_a: assert property ($rose(triggered) |-> trigger_out)
        else $error("triggered rose without pulse");
    trig_hold_a: assert property (triggered && !arm |=> triggered)
        else $error("triggered dropped without arm");
    disarm_stop_a: assert property (running && disarm |=> !running
        && !trigger_out) else $error("disarm did not stop");
    idle_still_a: assert property (!running && !arm |=> $stable(active_state)
        && $stable(progress_marker_zero) && $stable(event_count_zero))
        else $error("state moved while idle");
    cnt_step_a: assert property (running |=> event_count_zero == 16'h0000
        || $stable(event_count_zero)
        || event_count_zero == $past(event_count_zero) + 16'h0001)
        else $error("counter moved by more than one");
    run_cause_a: assert property ($rose(running) |-> $past(arm))
        else $error("run began without arm");
endmodule

bind trigger_sequencer_fsm trigger_sequencer_fsm_monitor mon (
    .sys_clk(sys_clk), .rst(rst), .arm(arm), .disarm(disarm),
    .running(running), .trigger_out(trigger_out), .triggered(triggered),
    .active_state(active_state), .progress_marker_zero(progress_marker_zero),
    .event_count_zero(event_count_zero)
);

// ===== tb/trigger_sequencer_fsm_test.sv
// self-checking bench for the trigger sequencer
// assumes the probe source model and the bound monitor are compiled with it
`timescale 1ns/1ps
`include "trig_seq_cfg.svh"

module trigger_sequencer_fsm_test import trig_seq_pkg::*; ();
    logic         sys_clk = 1'h0;
    logic         rst = 1'h1;
    logic         prog_we = 1'h0;
    logic [3:0]   prog_addr = 4'h0;
    state_body_t  prog_word = '0;
    cmp_op_t      cmp_op [4];
    logic [31:0]  cmp_value [4];
    logic [31:0]  cmp_care [4];
    counter_cmp_t cnt_cmp [4];
    logic         arm = 1'h0;
    logic         disarm = 1'h0;
    logic [31:0]  probe_next = 32'h0000_0000;
    logic [31:0]  probe;
    logic         running, trigger_out, triggered;
    logic [3:0]   active_state;
    logic         pm0, pm1, pm2, pm3;
    logic [15:0]  ec0, ec1, ec2, ec3;
    int           num_errors = 0;
    int           comparisons = 0;

    probe_source #(.PROBE_W(32)) src (.sys_clk(sys_clk), .rst(rst),
        .next_probe(probe_next), .probe(probe));
    trigger_sequencer_fsm #(.PROBE_W(32), .NUM_CMP(4)) dut (.sys_clk(sys_clk),
        .rst(rst), .probe(probe), .prog_we(prog_we), .prog_addr(prog_addr),
        .prog_word(prog_word), .cmp_op(cmp_op), .cmp_value(cmp_value),
        .cmp_care(cmp_care), .cnt_cmp(cnt_cmp), .arm(arm), .disarm(disarm),
        .running(running), .trigger_out(trigger_out), .triggered(triggered),
        .active_state(active_state), .progress_marker_zero(pm0),
        .progress_marker_one(pm1), .progress_marker_two(pm2),
        .progress_marker_three(pm3), .event_count_zero(ec0),
        .event_count_one(ec1), .event_count_two(ec2), .event_count_three(ec3));

    // 250 MHz sampling clock
    always #2 sys_clk = ~sys_clk;

    // inputs move only at the falling edge, away from sampling
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic action_block_t act(input logic [3:0] go, input logic fire,
                                          input logic [3:0] fset, input logic [3:0] inc);
        return action_block_t'{fire, go, fset, 4'h0, inc, 4'h0};
    endfunction

    // probe group ORed with the counter term
    function automatic condition_t cnd(input logic [15:0] m, input logic cu);
        return condition_t'{m, 1'h0, cu, 2'h3, 1'h0};
    endfunction

    task automatic wr(input logic [3:0] a, input branch_t k, input condition_t c1,
                      input condition_t c2, input action_block_t a1,
                      input action_block_t a2, input action_block_t ad);
        prog_we = 1'h1;
        prog_addr = a;
        prog_word = state_body_t'{k, c1, c2, a1, a2, ad};
        tick(1);
    endtask

    task automatic start;
        prog_we = 1'h0;
        arm = 1'h1;
        tick(1);
        arm = 1'h0;
    endtask

    task automatic stop;
        disarm = 1'h1;
        tick(1);
        disarm = 1'h0;
    endtask

    task automatic scen_reset;
        check(running, 0);
        check(active_state, 0);
        check(ec0, 0);
    endtask

    task automatic scen_oneway;
        wr(0, BR_ONE, '0, '0, act(1, 0, 0, 1), '0, '0);
        wr(1, BR_ONE, '0, '0, act(2, 0, 1, 0), '0, '0);
        wr(2, BR_ONE, '0, '0, act(0, 1, 0, 0), '0, '0);
        start;
        check(active_state, 0);
        tick(1);
        check(active_state, 1);
        check(ec0, 1);
        tick(1);
        check(active_state, 2);
        check(pm0, 1);
        tick(1);
        check({trigger_out, triggered, running}, 3'h6);
        tick(1);
        check({trigger_out, pm0}, 2'h1);
    endtask

    task automatic scen_twoway;
        cmp_value[0] = 32'h0000_0005;
        wr(0, BR_TWO, cnd(16'h0001, 0), '0, act(1, 0, 0, 0), '0, act(0, 0, 0, 2));
        wr(1, BR_ONE, '0, '0, act(0, 1, 0, 0), '0, '0);
        start;
        tick(3);
        check(active_state, 0);
        check(ec1, 3);
        probe_next = 32'h0000_0005;
        tick(2);
        check(active_state, 1);
        check(ec1, 4);
        tick(1);
        check(trigger_out, 1);
    endtask

    task automatic scen_threeway;
        logic [31:0] pv [3] = '{32'h0000_0003, 32'h0000_0002, 32'h0000_0009};
        logic [3:0]  es [3] = '{4'h3, 4'h4, 4'h0};
        // probe 3 meets both conditions, so the first must win
        cmp_value[1] = 32'h0000_0003;
        cmp_value[2] = 32'h0000_0004;
        wr(0, BR_THREE, cnd(16'h0002, 0), cnd(16'h0004, 0), act(3, 0, 2, 0),
           act(4, 0, 4, 0), act(0, 0, 0, 4));
        wr(3, BR_ONE, '0, '0, act(0, 1, 0, 0), '0, '0);
        wr(4, BR_ONE, '0, '0, act(0, 1, 0, 0), '0, '0);
        for (int i = 0; i < 3; i++) begin
            probe_next = pv[i];
            tick(2);
            start;
            tick(1);
            check(active_state, es[i]);
            check({pm1, pm2, ec2[0]}, {es[i] == 3, es[i] == 4, es[i] == 0});
            tick(1);
            check(trigger_out, es[i] != 0);
            stop;
            tick(1);
        end
    endtask

    task automatic scen_counter;
        int n;
        wr(0, BR_TWO, cnd(16'h0010, 1), '0, act(0, 1, 8, 0), '0, act(0, 0, 0, 8));
        // first pass equality, second pass inequality against zero
        for (int r = 0; r < 2; r++) begin
            cnt_cmp[3] = (r == 0) ? counter_cmp_t'{CNT_EQ, 16'h0003}
                                  : counter_cmp_t'{CNT_NE, 16'h0000};
            start;
            for (n = 0; n < 10 && trigger_out !== 1'h1; n++) begin
                tick(1);
            end
            check(16'(n), (r == 0) ? 16'h0004 : 16'h0002);
            check(ec3, (r == 0) ? 16'h0003 : 16'h0001);
            check(pm3, 16'h0001);
            if (n == 10) begin
                conclude();
            end
        end
    endtask

    function automatic logic ref_cmp(input cmp_op_t op, input logic [31:0] p);
        case (op)
            OP_EQ: return p == 32'h0000_0007;
            OP_NE: return p != 32'h0000_0007;
            OP_GT: return p > 32'h0000_0007;
            OP_LT: return p < 32'h0000_0007;
            OP_GE: return p >= 32'h0000_0007;
            OP_LE: return p <= 32'h0000_0007;
            OP_NO_EDGE: return 1'h1;
            default: return 1'h0;
        endcase
    endfunction

    // probe held steady, so of the edge ops only no-edge may fire; then rise, fall, any-edge each see an edge
    task automatic scen_ops;
        cmp_value[0] = 32'h0000_0007;
        wr(0, BR_TWO, cnd(16'h0001, 0), '0, act(0, 1, 0, 0), '0, act(0, 0, 0, 0));
        for (int k = 0; k < 10; k++) begin
            for (int p = 5; p < 10; p += 2) begin
                cmp_op[0] = cmp_op_t'(k);
                probe_next = 32'(p);
                tick(2);
                start;
                tick(2);
                check(triggered, ref_cmp(cmp_op[0], probe_next));
                stop;
                tick(1);
            end
        end
        for (int e = 0; e < 3; e++) begin
            cmp_op[0] = cmp_op_t'(6 + e);
            probe_next = 32'(e == 1);
            tick(2);
            start;
            tick(2);
            check(triggered, 0);
            probe_next = 32'(e != 1);
            tick(2);
            check(triggered, 1);
            stop;
            tick(1);
        end
    endtask

    task automatic conclude;
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        for (int i = 0; i < 4; i++) begin
            cmp_op[i] = (i == 1) ? OP_EQ : OP_LT;
            cmp_value[i] = 32'(i);
            cmp_care[i] = 32'hFFFF_FFFF;
            cnt_cmp[i] = '0;
        end
        cmp_op[0] = OP_EQ;
        cmp_value[3] = 32'h0000_0000;
        tick(6);
        rst = 1'h0;
        tick(1);
        scen_reset();
        scen_oneway();
        scen_twoway();
        scen_threeway();
        scen_counter();
        scen_ops();
        conclude();
    end
endmodule
